// ---- include/tactl_pkg.sv ----
// constants and types shared by the type A timer control block
// assumes a 32-bit register port with byte offsets on an 8-bit address
package tactl_pkg;
  localparam int TACTL_AW = 8;
  localparam logic [TACTL_AW-1:0] TACTL_CTRL_OFS = 8'h00;
  localparam logic [TACTL_AW-1:0] TACTL_COUNT_OFS = 8'h04;
  localparam int TACTL_ON_BIT = 15;
  localparam int TACTL_IDLE_STOP_BIT = 13;
  localparam int TACTL_WR_BLOCK_BIT = 12;
  localparam int TACTL_WR_PEND_BIT = 11;
  localparam int TACTL_GATE_EN_BIT = 7;
  localparam int TACTL_DIV_HI_BIT = 5;
  localparam int TACTL_DIV_LO_BIT = 4;
  localparam int TACTL_SYNC_BIT = 2;
  localparam int TACTL_CSRC_BIT = 1;
  localparam logic [31:0] TACTL_CTRL_WMASK = 32'h0000B0B6;
  localparam logic [31:0] TACTL_CTRL_RESET = 32'h00000000;
  localparam logic [15:0] TACTL_COUNT_RESET = 16'h0000;
  localparam logic [7:0] TACTL_DIV1_LIM = 8'h00;
  localparam logic [7:0] TACTL_DIV8_LIM = 8'h07;
  localparam logic [7:0] TACTL_DIV64_LIM = 8'h3F;
  localparam logic [7:0] TACTL_DIV256_LIM = 8'hFF;
  localparam logic [1:0] TACTL_SEL_DIV1 = 2'h0;
  localparam logic [1:0] TACTL_SEL_DIV8 = 2'h1;
  localparam logic [1:0] TACTL_SEL_DIV64 = 2'h2;
  localparam logic [1:0] TACTL_SEL_DIV256 = 2'h3;
  typedef enum logic [1:0] {
    TACTL_WR_IDLE = 2'b01,
    TACTL_WR_PEND = 2'b10
  } tactl_wr_e;
endpackage

// ---- design/tactl_prescaler.sv ----
// input prescaler of the type A timer: passes one tick in 1, 8, 64 or 256
// assumes input ticks are single-cycle pulses on i_clk
`timescale 1ns/1ns
`default_nettype none
module tactl_prescaler
  import tactl_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_en,
  input wire logic [1:0] i_sel,
  input wire logic i_tick,
  output logic o_tick
);
  typedef struct packed {
    logic [7:0] cnt;
  } tactl_psc_s;

  tactl_psc_s st_reg;
  tactl_psc_s st_next;
  logic [7:0] lim;

  always_comb begin
    case (i_sel)
      TACTL_SEL_DIV8: lim = TACTL_DIV8_LIM;
      TACTL_SEL_DIV64: lim = TACTL_DIV64_LIM;
      TACTL_SEL_DIV256: lim = TACTL_DIV256_LIM;
      default: lim = TACTL_DIV1_LIM;
    endcase
  end

  assign o_tick = i_en && i_tick && (st_reg.cnt >= lim);

  always_comb begin
    st_next = st_reg;
    // a disabled timer restarts its prescale phase from zero
    if (!i_en) begin
      st_next.cnt = 8'h00;
    end else if (i_tick) begin
      st_next.cnt = (st_reg.cnt >= lim) ? 8'h00 : st_reg.cnt + 8'h01;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  div_one_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (i_en && i_tick && i_sel == TACTL_SEL_DIV1) |-> o_tick)
    else $error("1:1 prescale dropped a tick");
  div_eight_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (o_tick && i_sel == TACTL_SEL_DIV8) |-> st_reg.cnt == TACTL_DIV8_LIM)
    else $error("1:8 prescale ticked at wrong phase");
endmodule
`default_nettype wire

// ---- design/tactl_top.sv ----
// type A 16-bit timer: control register, count register, prescaler and gate
// assumes a plain register port with read data one cycle after the strobe
// and an external timer clock input that is already synchronous to i_clk
//
// Summary of operation
// - the timer counts only while the enable bit 15 is set.
// - with idle-stop bit 13 set the timer halts in idle mode, otherwise it runs.
// - with write-block bit 12 set, count writes are dropped while one is pending.
// - in asynchronous mode bit 11 reads one while a count write is crossing over.
// - in synchronous mode bit 11 always reads zero.
// - with external clock source selected the gate enable bit 7 has no effect.
// - with internal clock source, bit 7 turns gated accumulation on and off.
// - bits 5:4 divide the input clock by 256, 64, 8 or 1 for codes 11, 10, 01, 00.
// - bits 31:16, 14, 10:8, 6, 3 and 0 ignore writes and read as zero.
//
// Implementation choices: the strobed register port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
module tactl_top
  import tactl_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic [TACTL_AW-1:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  input wire logic i_idle,
  input wire logic i_ext_clk,
  input wire logic i_gate,
  output logic [15:0] o_count
);
  typedef struct packed {
    logic [31:0] ctrl;
    logic [15:0] count;
    logic [15:0] pend_data;
    tactl_wr_e wstate;
    logic ext_prev;
    logic [31:0] rdata;
  } tactl_top_s;

  tactl_top_s st_reg;
  tactl_top_s st_next;

  logic on;
  logic csrc_ext;
  logic async_mode;
  logic running;
  logic ext_edge;
  logic gate_active;
  logic src_tick;
  logic psc_tick;
  logic count_wr;
  logic pending;
  logic wr_accept;
  logic ld_now;
  logic [15:0] ld_val;
  logic [31:0] ctrl_view;

  assign on = st_reg.ctrl[TACTL_ON_BIT];
  assign csrc_ext = st_reg.ctrl[TACTL_CSRC_BIT];
  assign async_mode = csrc_ext && !st_reg.ctrl[TACTL_SYNC_BIT];
  assign pending = (st_reg.wstate == TACTL_WR_PEND);
  assign ext_edge = i_ext_clk && !st_reg.ext_prev;
  // idle only freezes the timer when software asked for it
  assign running = on && !(st_reg.ctrl[TACTL_IDLE_STOP_BIT] && i_idle);
  assign gate_active = !csrc_ext && st_reg.ctrl[TACTL_GATE_EN_BIT];
  always_comb begin
    if (csrc_ext) begin
      src_tick = ext_edge;
    end else if (gate_active) begin
      src_tick = i_gate;
    end else begin
      src_tick = 1'b1;
    end
  end

  tactl_prescaler u_psc (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_en(running),
    .i_sel(st_reg.ctrl[TACTL_DIV_HI_BIT:TACTL_DIV_LO_BIT]),
    .i_tick(src_tick),
    .o_tick(psc_tick)
  );

  assign count_wr = i_wr && (i_addr == TACTL_COUNT_OFS);
  // blocking mode drops a second write rather than corrupting one in flight
  assign wr_accept = count_wr && !(pending && st_reg.ctrl[TACTL_WR_BLOCK_BIT]);

  always_comb begin
    ld_now = 1'b0;
    ld_val = st_reg.pend_data;
    if (!async_mode && count_wr) begin
      ld_now = 1'b1;
      ld_val = i_wdata[15:0];
    end else if (async_mode && pending && ext_edge) begin
      ld_now = 1'b1;
    end
  end

  always_comb begin
    ctrl_view = st_reg.ctrl & TACTL_CTRL_WMASK;
    ctrl_view[TACTL_WR_PEND_BIT] = async_mode && pending;
  end

  always_comb begin
    st_next = st_reg;
    st_next.ext_prev = i_ext_clk;
    if (i_wr && i_addr == TACTL_CTRL_OFS) begin
      st_next.ctrl = i_wdata & TACTL_CTRL_WMASK;
    end
    if (ld_now) begin
      st_next.count = ld_val;
    end else if (psc_tick) begin
      st_next.count = st_reg.count + 16'h0001;
    end
    case (st_reg.wstate)
      TACTL_WR_IDLE: begin
        if (async_mode && wr_accept) begin
          st_next.pend_data = i_wdata[15:0];
          st_next.wstate = TACTL_WR_PEND;
        end
      end
      TACTL_WR_PEND: begin
        if (!async_mode) begin
          st_next.wstate = TACTL_WR_IDLE;
        end else if (wr_accept) begin
          // back-to-back write replaces the data still waiting
          st_next.pend_data = i_wdata[15:0];
        end else if (ext_edge) begin
          st_next.wstate = TACTL_WR_IDLE;
        end
      end
      default: st_next.wstate = TACTL_WR_IDLE;
    endcase
    st_next.rdata = 32'h00000000;
    if (i_rd) begin
      case (i_addr)
        TACTL_CTRL_OFS: st_next.rdata = ctrl_view;
        TACTL_COUNT_OFS: st_next.rdata = {16'h0000, st_reg.count};
        default: st_next.rdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      st_reg.ctrl <= TACTL_CTRL_RESET;
      st_reg.count <= TACTL_COUNT_RESET;
      st_reg.pend_data <= TACTL_COUNT_RESET;
      st_reg.wstate <= TACTL_WR_IDLE;
      st_reg.ext_prev <= 1'b0;
      st_reg.rdata <= 32'h00000000;
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_rdata = st_reg.rdata;
  assign o_count = st_reg.count;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);

  off_hold_a: assert property ((!on && !ld_now) |=> $stable(o_count))
    else $error("count moved while disabled");
  idle_hold_a: assert property
    ((st_reg.ctrl[TACTL_IDLE_STOP_BIT] && i_idle && !ld_now) |=> $stable(o_count))
    else $error("count moved in idle with stop set");
  block_drop_a: assert property
    ((pending && async_mode && st_reg.ctrl[TACTL_WR_BLOCK_BIT] && count_wr)
     |=> $stable(st_reg.pend_data))
    else $error("blocked count write was taken");
  pend_set_a: assert property
    ((async_mode && wr_accept && !(i_wr && i_addr == TACTL_CTRL_OFS))
     |=> pending && st_reg.pend_data == $past(i_wdata[15:0]))
    else $error("async count write did not go pending");
  sync_zero_a: assert property
    ((i_rd && i_addr == TACTL_CTRL_OFS && !async_mode) |=> !o_rdata[TACTL_WR_PEND_BIT])
    else $error("pending flag seen in synchronous mode");
  src_ext_a: assert property
    ((csrc_ext && !ext_edge && !ld_now) |=> $stable(o_count))
    else $error("external source counted without an edge");
  gate_low_a: assert property
    ((gate_active && !i_gate && !ld_now) |=> $stable(o_count))
    else $error("gated count moved with gate low");
  unimpl_zero_a: assert property
    ((i_rd && i_addr == TACTL_CTRL_OFS)
     |=> (o_rdata & ~(TACTL_CTRL_WMASK | 32'h00000800)) == 32'h00000000)
    else $error("unimplemented control bit read as one");
  count_inc_a: assert property
    ((psc_tick && !ld_now) |=> o_count == $past(o_count) + 16'h0001)
    else $error("count did not step on a tick");
  sync_load_a: assert property
    ((count_wr && !async_mode) |=> o_count == $past(i_wdata[15:0]))
    else $error("synchronous count write not loaded");

  async_done_c: cover property (pending ##[1:20] !pending);
  gated_run_c: cover property (gate_active && i_gate && psc_tick);
  div256_c: cover property
    (psc_tick && st_reg.ctrl[TACTL_DIV_HI_BIT:TACTL_DIV_LO_BIT] == TACTL_SEL_DIV256);
  idle_stop_c: cover property (on && st_reg.ctrl[TACTL_IDLE_STOP_BIT] && i_idle);
endmodule
`default_nettype wire

// ---- tb/test_type_a_timer_control.sv ----
// self-checking bench for the type A timer control block (tactl_top)
// assumes the register map and bit positions of tactl_pkg and a 250 MHz clock
`timescale 1ns/1ns
`default_nettype none
module test_type_a_timer_control
  import tactl_pkg::*;
;
  logic i_clk, i_resetn, i_wr, i_rd, i_idle, i_ext_clk, i_gate, rd_d;
  logic [TACTL_AW-1:0] i_addr, addr_d;
  logic [31:0] i_wdata, o_rdata, rnd;
  logic [15:0] o_count;
  logic [31:0] exp_q[$];
  int error_cnt = 0;
  int num_checks = 0;
  int cyc_cnt = 0;

  tactl_top u_dut (.i_clk(i_clk), .i_resetn(i_resetn), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_idle(i_idle), .i_ext_clk(i_ext_clk),
    .i_gate(i_gate), .o_count(o_count));

  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    cyc(1);
    i_wr <= 1'b0;
    // idle cycle after every write keeps clear of a just-disabled timer
    cyc(1);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    i_rd <= 1'b1;
    i_addr <= a;
    exp_q.push_back(exp);
    cyc(1);
    i_rd <= 1'b0;
    cyc(1);
  endtask

  // gate held high for exactly g sampling edges, then settle
  task automatic gate_pulse(input int g);
    i_gate <= 1'b1;
    cyc(g);
    i_gate <= 1'b0;
    cyc(4);
  endtask

  task automatic ext_pulse();
    i_ext_clk <= 1'b1;
    cyc(3);
    i_ext_clk <= 1'b0;
    cyc(3);
  endtask

  // read data belong to the cycle after the strobe only
  always @(posedge i_clk) begin
    rd_d <= i_rd;
    addr_d <= i_addr;
    if (rd_d) begin
      if (exp_q.size() == 0) begin
        check("rdata unexpected", o_rdata, 32'hFFFFFFFF);
      end else begin
        // count reads happen with the timer stopped, so the pin must agree
        if (addr_d == TACTL_COUNT_OFS) check("count", {16'h0000, o_count}, exp_q[0]);
        check("rdata", o_rdata, exp_q.pop_front());
      end
    end
  end

  always @(posedge i_clk) begin
    cyc_cnt++;
    if (cyc_cnt == 20000) begin
      error_cnt++;
      stop_test();
    end
  end

  initial begin
    int divs[4];
    int g;
    divs = '{1, 8, 64, 256};
    i_resetn = 1'b0;
    {i_wr, i_rd, i_idle, i_ext_clk, i_gate} = 5'h00;
    i_addr = 8'h00;
    i_wdata = 32'h00000000;
    void'($urandom(77853));
    cyc(8);
    i_resetn <= 1'b1;
    cyc(1);
    rd(TACTL_CTRL_OFS, 32'h00000000);
    rd(TACTL_COUNT_OFS, 32'h00000000);
    wr(TACTL_CTRL_OFS, 32'hFFFFFFFF);
    rd(TACTL_CTRL_OFS, 32'h0000B0B6);
    rd(8'h08, 32'h00000000);
    wr(TACTL_CTRL_OFS, 32'h00000000);
    rnd = $urandom();
    wr(TACTL_COUNT_OFS, rnd);
    rd(TACTL_CTRL_OFS, 32'h00000000);
    cyc(20);
    rd(TACTL_COUNT_OFS, {16'h0000, rnd[15:0]});
    // every prescale code, gated so the tick count is exact
    for (int s = 0; s < 4; s++) begin
      g = (s == 0) ? 5 : divs[s] * 2 + divs[s] / 2;
      wr(TACTL_COUNT_OFS, 32'h00000000);
      wr(TACTL_CTRL_OFS, 32'h00008080 | (s << 4));
      gate_pulse(g);
      wr(TACTL_CTRL_OFS, 32'h00000000);
      rd(TACTL_COUNT_OFS, (s == 0) ? 32'h00000005 : 32'h00000002);
    end
    // external source ignores the gate enable
    wr(TACTL_COUNT_OFS, 32'h00000000);
    wr(TACTL_CTRL_OFS, 32'h00008086);
    repeat (3) ext_pulse();
    wr(TACTL_CTRL_OFS, 32'h00000000);
    rd(TACTL_COUNT_OFS, 32'h00000003);
    wr(TACTL_COUNT_OFS, 32'h00000000);
    i_idle <= 1'b1;
    wr(TACTL_CTRL_OFS, 32'h0000A080);
    gate_pulse(5);
    wr(TACTL_CTRL_OFS, 32'h00008080);
    gate_pulse(7);
    wr(TACTL_CTRL_OFS, 32'h00000000);
    i_idle <= 1'b0;
    rd(TACTL_COUNT_OFS, 32'h00000007);
    // asynchronous loads: pending flag, replace, then block
    wr(TACTL_CTRL_OFS, 32'h00000002);
    wr(TACTL_COUNT_OFS, 32'h00000055);
    rd(TACTL_CTRL_OFS, 32'h00000802);
    wr(TACTL_COUNT_OFS, 32'h00000066);
    ext_pulse();
    rd(TACTL_CTRL_OFS, 32'h00000002);
    rd(TACTL_COUNT_OFS, 32'h00000066);
    wr(TACTL_CTRL_OFS, 32'h00001002);
    wr(TACTL_COUNT_OFS, 32'h00000011);
    wr(TACTL_COUNT_OFS, 32'h00000022);
    ext_pulse();
    rd(TACTL_COUNT_OFS, 32'h00000011);
    rd(TACTL_CTRL_OFS, 32'h00001002);
    cyc(4);
    stop_test();
  end
endmodule
`default_nettype wire
